// ==== src/pbb_bridge.sv ====
// pci target bridge onto an 8-bit data, 24-bit address byte bus, with apb control register
//
// Functional notes
// - one control register at fixed address
// - bit 7 enables byte bus, resets off
// - bits 10:8 give 0..7 wait states
// - divider period is field plus one
// - boot strap picks clock pin direction
// - read word: data byte over address
// - write drives top byte, address below
// - byte address is word offset over four
// - accept single and burst target transfers
// - bursts insert wait states per byte
// - read strobes lengthened by wait states
// - write strobes delayed by wait states
// - release lines outside active drive
// - pins reused as address, data, strobes
// - target ready only after wait states
// - interrupt b pin is global select
`timescale 1ns/1ps

module pbb_bridge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clk_gen_strap,
    output logic pci_clk_out,
    output logic pci_clk_oe,
    input wire logic frame_n_in,
    input wire logic irdy_n_in,
    input wire logic [3:0] cbe_n_in,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic [31:0] ad_oe,
    output logic [3:0] cbe_n_out,
    output logic cbe_oe,
    output logic trdy_n_out,
    output logic trdy_oe,
    output logic devsel_n_out,
    output logic devsel_oe,
    output logic intb_n_out,
    output logic intb_oe
);
    import pbb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    pbb_state_t st;
    pbb_state_t nx;
    logic frame_fall;
    logic irdy_low;
    logic frame_low;
    logic [3:0] cmd;
    logic stb_act;
    logic rd_lo;
    logic wr_lo;
    logic apb_wr_ctrl;

    // a changed level only counts once stages two and three agree
    function automatic logic [PBB_SY_W-1:0] agree(
        input logic [PBB_SY_W-1:0] old,
        input logic [PBB_SY_W-1:0] a,
        input logic [PBB_SY_W-1:0] b
    );
        agree = ((a ~^ b) & a) | ((a ^ b) & old);
    endfunction

    function automatic logic base_hit(input logic [31:0] a, input logic [5:0] base);
        base_hit = a[PBB_BASE_HI:PBB_BASE_LO] == base;
    endfunction

    // high for the first half of the period; odd fields give an even split
    function automatic logic clk_high(input logic [4:0] cnt, input logic [4:0] div);
        logic [5:0] half;
        half = ({1'h0, div} + 6'h01) >> 1;
        clk_high = {1'h0, cnt} < half;
    endfunction

    function automatic logic [31:0] ctrl_word(input pbb_state_t s);
        logic [31:0] w;
        w = '0;
        w[PBB_BASE_HI:PBB_BASE_LO] = s.base;
        w[PBB_WS_HI:PBB_WS_LO] = s.ws;
        w[PBB_EN_BIT] = s.en;
        w[PBB_DIV_HI:PBB_DIV_LO] = s.div;
        ctrl_word = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    assign frame_fall = st.frame_prev && !st.flt[PBB_SY_FRAME];
    assign irdy_low = !st.flt[PBB_SY_IRDY];
    assign frame_low = !st.flt[PBB_SY_FRAME];
    assign cmd = st.flt[PBB_SY_CBE_HI:PBB_SY_CBE_LO];
    assign apb_wr_ctrl = psel && penable && pwrite && (paddr == PBB_CTRL_ADDR);

    always_comb
    begin
        nx = st;
        nx.s1 = {frame_n_in, irdy_n_in, cbe_n_in, ad_in};
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        nx.flt = agree(st.flt, st.s2, st.s3);
        nx.frame_prev = st.flt[PBB_SY_FRAME];

        // strap is caught once, on the first enabled edge after reset release
        if (!st.strap_done)
        begin
            nx.strap_done = 1'h1;
            nx.clk_gen = clk_gen_strap;
        end

        // >= guards against a new divider below the running count
        if (st.clk_cnt >= st.div)
        begin
            nx.clk_cnt = '0;
        end
        else
        begin
            nx.clk_cnt = st.clk_cnt + 5'h01;
        end
        nx.clk_q = clk_high(nx.clk_cnt, st.div);

        // read data and error are fixed in the setup cycle
        if (psel && !penable)
        begin
            nx.pslverr = paddr != PBB_CTRL_ADDR;
            nx.prdata = (paddr == PBB_CTRL_ADDR) ? ctrl_word(st) : '0;
        end
        if (apb_wr_ctrl)
        begin
            nx.base = pwdata[PBB_BASE_HI:PBB_BASE_LO];
            nx.ws = pwdata[PBB_WS_HI:PBB_WS_LO];
            nx.en = pwdata[PBB_EN_BIT];
            // an illegal zero divider would stall the clock, so it is not taken
            if (pwdata[PBB_DIV_HI:PBB_DIV_LO] != PBB_DIV_ILLEGAL)
            begin
                nx.div = pwdata[PBB_DIV_HI:PBB_DIV_LO];
            end
        end

        nx.rd_len = '0;
        unique case (st.fsm)
            PBB_IDLE:
            begin
                if (frame_fall && st.en && base_hit(st.flt[31:0], st.base) &&
                    (cmd == PBB_CMD_MEM_RD || cmd == PBB_CMD_MEM_WR))
                begin
                    nx.fsm = PBB_CLAIM;
                    nx.wr = cmd == PBB_CMD_MEM_WR;
                    nx.addr = st.flt[PBB_BA_HI:PBB_BA_LO];
                end
            end
            PBB_CLAIM:
            begin
                if (irdy_low)
                begin
                    if (st.wr)
                    begin
                        nx.data = st.flt[PBB_DATA_HI:PBB_DATA_LO];
                    end
                    nx.wcnt = '0;
                    nx.fsm = PBB_STROBE;
                end
                else if (!frame_low)
                begin
                    nx.fsm = PBB_IDLE;
                end
            end
            PBB_STROBE:
            begin
                if (!st.wr)
                begin
                    nx.rd_len = st.rd_len + 4'h1;
                end
                // the read byte passes the pin filter: under four waits it is stale
                if (st.wcnt == st.ws)
                begin
                    if (!st.wr)
                    begin
                        nx.data = st.flt[PBB_DATA_HI:PBB_DATA_LO];
                    end
                    nx.fsm = PBB_PRESENT;
                end
                else
                begin
                    nx.wcnt = st.wcnt + 3'h1;
                end
            end
            PBB_PRESENT:
            begin
                if (irdy_low)
                begin
                    if (frame_low)
                    begin
                        nx.addr = st.addr + 24'h000001;
                        nx.fsm = PBB_CLAIM;
                    end
                    else
                    begin
                        nx.fsm = PBB_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.base <= PBB_BASE_RESET;
            st.ws <= PBB_WS_RESET;
            st.en <= PBB_EN_RESET;
            st.div <= PBB_DIV_RESET;
            st.s1 <= '1;
            st.s2 <= '1;
            st.s3 <= '1;
            st.flt <= '1;
            st.frame_prev <= 1'h1;
            st.fsm <= PBB_IDLE;
        end
        else if (pce)
        begin
            st <= nx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // pins other than the generated clock are only driven while a transfer is claimed
    assign stb_act = st.fsm == PBB_STROBE;
    assign rd_lo = stb_act && !st.wr;
    assign wr_lo = stb_act && st.wr && (st.wcnt == st.ws);

    always_comb
    begin
        cbe_n_out = '1;
        cbe_n_out[PBB_STB_RD] = !rd_lo;
        cbe_n_out[PBB_STB_WR] = !wr_lo;
        cbe_n_out[PBB_STB_DS] = !(rd_lo || wr_lo);
        cbe_n_out[PBB_STB_SPARE] = 1'h1;
        ad_out = {st.data, st.addr};
        ad_oe = PBB_OE_NONE;
        if (stb_act)
        begin
            ad_out = st.wr ? {st.data, st.addr} : {PBB_BYTE_IDLE, st.addr};
            ad_oe = st.wr ? PBB_OE_ALL : PBB_OE_ADDR;
        end
        else if (st.fsm == PBB_PRESENT && !st.wr)
        begin
            ad_oe = PBB_OE_ALL;
        end
    end

    assign cbe_oe = stb_act;
    assign trdy_n_out = st.fsm != PBB_PRESENT;
    assign trdy_oe = st.fsm != PBB_IDLE;
    assign devsel_n_out = st.fsm == PBB_IDLE;
    assign devsel_oe = st.fsm != PBB_IDLE;
    assign intb_n_out = st.fsm == PBB_IDLE;
    assign intb_oe = st.fsm != PBB_IDLE;
    assign pci_clk_out = st.clk_q;
    assign pci_clk_oe = st.clk_gen;
    assign prdata = st.prdata;
    assign pslverr = st.pslverr;
    // ready follows the enable, so a frozen block holds the bus master off
    assign pready = pce;

    ////////////////////////////////////////////////////////////////////////////////

    sequence s_claim;
        pce && st.fsm == PBB_IDLE ##1 st.fsm == PBB_CLAIM;
    endsequence

    sequence s_rd_done;
        pce && rd_lo ##1 !rd_lo;
    endsequence

    a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
        pce && apb_wr_ctrl |=> st.en == $past(pwdata[PBB_EN_BIT]))
        else $error("enable bit not loaded");

    a_ws_readback: assert property (@(posedge pclk) disable iff (!presetn)
        pce && apb_wr_ctrl ##2 pce && psel && !penable && paddr == PBB_CTRL_ADDR
        |=> prdata[PBB_WS_HI:PBB_WS_LO] == $past(pwdata[PBB_WS_HI:PBB_WS_LO], 3))
        else $error("wait field readback wrong");

    a_no_claim_off: assert property (@(posedge pclk) disable iff (!presetn)
        pce && st.fsm == PBB_IDLE && !st.en |=> st.fsm == PBB_IDLE && cbe_oe == 1'h0)
        else $error("claimed while disabled");

    a_addr_map: assert property (@(posedge pclk) disable iff (!presetn)
        s_claim |-> st.addr == $past(st.flt[PBB_BA_HI:PBB_BA_LO]) &&
        $past(base_hit(st.flt[31:0], st.base)))
        else $error("byte bus address not word offset");

    a_rd_strobe_len: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd_done |-> st.rd_len == {1'h0, st.ws} + 4'h1)
        else $error("read strobe length not waits plus one");

    a_wr_strobe_late: assert property (@(posedge pclk) disable iff (!presetn)
        !cbe_n_out[PBB_STB_WR] |-> !cbe_n_out[PBB_STB_DS] && st.wcnt == st.ws)
        else $error("write strobe before waits elapsed");

    a_trdy_after: assert property (@(posedge pclk) disable iff (!presetn)
        pce && $fell(trdy_n_out) |-> $past(stb_act) && $past(st.wcnt) == $past(st.ws))
        else $error("target ready before waits");

    a_read_format: assert property (@(posedge pclk) disable iff (!presetn)
        pce && rd_lo && st.wcnt == st.ws |=> ad_out[PBB_DATA_HI:PBB_DATA_LO] ==
        $past(st.flt[PBB_DATA_HI:PBB_DATA_LO]) && ad_oe == PBB_OE_ALL && !trdy_n_out)
        else $error("read word format wrong");

    a_gcs_active: assert property (@(posedge pclk) disable iff (!presetn)
        stb_act |-> intb_oe && !intb_n_out && !devsel_n_out)
        else $error("global select missing during transfer");

    a_release_idle: assert property (@(posedge pclk) disable iff (!presetn)
        st.fsm == PBB_IDLE |-> ad_oe == PBB_OE_NONE && !cbe_oe && !trdy_oe && !intb_oe)
        else $error("lines driven while idle");

    a_clk_period: assert property (@(posedge pclk) disable iff (!presetn)
        pce && st.clk_cnt == st.div && !apb_wr_ctrl |=> st.clk_cnt == '0)
        else $error("divider period wrong");

endmodule // pbb_bridge

// ==== src/pbb_pkg.sv ====
// package: constants, register layout and state types of the pci byte bus bridge
package pbb_pkg;

    // register map
    localparam logic [31:0] PBB_CTRL_ADDR = 32'h0010_3060;
    localparam int PBB_BASE_HI = 31;
    localparam int PBB_BASE_LO = 26;
    localparam int PBB_WS_HI = 10;
    localparam int PBB_WS_LO = 8;
    localparam int PBB_EN_BIT = 7;
    localparam int PBB_DIV_HI = 4;
    localparam int PBB_DIV_LO = 0;
    localparam logic [5:0] PBB_BASE_RESET = 6'h00;
    localparam logic [2:0] PBB_WS_RESET = 3'h0;
    localparam logic PBB_EN_RESET = 1'h0;
    localparam logic [4:0] PBB_DIV_RESET = 5'h1f;
    localparam logic [4:0] PBB_DIV_ILLEGAL = 5'h00;

    // pci commands accepted by the target
    localparam logic [3:0] PBB_CMD_MEM_RD = 4'h6;
    localparam logic [3:0] PBB_CMD_MEM_WR = 4'h7;

    // address/data pin layout during the byte bus data phase
    localparam int PBB_BA_HI = 25;
    localparam int PBB_BA_LO = 2;
    localparam int PBB_DATA_HI = 31;
    localparam int PBB_DATA_LO = 24;
    localparam logic [31:0] PBB_OE_NONE = 32'h0000_0000;
    localparam logic [31:0] PBB_OE_ADDR = 32'h00ff_ffff;
    localparam logic [31:0] PBB_OE_ALL = 32'hffff_ffff;
    localparam logic [7:0] PBB_BYTE_IDLE = 8'h00;

    // strobe positions on the byte enable pins
    localparam int PBB_STB_RD = 0;
    localparam int PBB_STB_WR = 1;
    localparam int PBB_STB_DS = 2;
    localparam int PBB_STB_SPARE = 3;

    // synchroniser vector: {frame_n, irdy_n, cbe_n[3:0], ad[31:0]}
    localparam int PBB_SY_W = 38;
    localparam int PBB_SY_FRAME = 37;
    localparam int PBB_SY_IRDY = 36;
    localparam int PBB_SY_CBE_HI = 35;
    localparam int PBB_SY_CBE_LO = 32;

    typedef enum logic [1:0] {
        PBB_IDLE,
        PBB_CLAIM,
        PBB_STROBE,
        PBB_PRESENT
    } pbb_fsm_t;

    typedef struct packed {
        logic [5:0] base;
        logic [2:0] ws;
        logic en;
        logic [4:0] div;
        logic [31:0] prdata;
        logic pslverr;
        logic [PBB_SY_W-1:0] s1;
        logic [PBB_SY_W-1:0] s2;
        logic [PBB_SY_W-1:0] s3;
        logic [PBB_SY_W-1:0] flt;
        logic frame_prev;
        logic strap_done;
        logic clk_gen;
        logic [4:0] clk_cnt;
        logic clk_q;
        pbb_fsm_t fsm;
        logic wr;
        logic [23:0] addr;
        logic [7:0] data;
        logic [2:0] wcnt;
        logic [3:0] rd_len;
    } pbb_state_t;

endpackage

// ==== sim/pbb_byte_mem.sv ====
// byte wide memory model standing on the far side of the byte bus
`timescale 1ns/1ps

module pbb_byte_mem (
    input wire logic pclk,
    input wire logic [31:0] ad,
    input wire logic [3:0] strobe_n,
    input wire logic sel_n,
    input wire logic [2:0] lag,
    output logic [7:0] rdata,
    output logic rdata_oe
);
    logic [7:0] mem [0:255];
    logic [2:0] cnt = 3'h0;

    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;
    end

    ////////////////////////////////////////
    // lag lets a slow device hold its data back a few strobe cycles
    always @(posedge pclk)
        cnt <= strobe_n[0] ? 3'h0 : cnt + 3'h1;

    // drives only while selected and read enabled, else the bench floats the lines
    assign rdata_oe = !sel_n && !strobe_n[0] && !strobe_n[2] && cnt >= lag;
    assign rdata = mem[ad[7:0]];

    always @(posedge pclk)
    begin
        if (!sel_n && !strobe_n[1] && !strobe_n[2])
            mem[ad[7:0]] <= ad[31:24];
    end
endmodule // pbb_byte_mem

// ==== sim/pbb_bridge_tb.sv ====
// self-checking bench for the pci byte bus bridge with a byte memory partner
`timescale 1ns/1ps

module pbb_bridge_tb;
    import pbb_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, frame_n, irdy_n, i_ad_oe, i_cbe_oe, flt;
    logic [31:0] paddr, pwdata, prdata, ad_in, ad_out, ad_oe, i_ad, wr_seen;
    logic [3:0] i_cbe, cbe_n_in, cbe_n_out;
    logic [7:0] m_dat;
    logic [2:0] lag;
    logic pready, pslverr, pci_clk_out, pci_clk_oe, cbe_oe, trdy_n_out, trdy_oe;
    logic devsel_n_out, devsel_oe, intb_n_out, intb_oe, m_oe, claimed, pce;
    int err_count, compares, cyc, rd_lo, wr_lo, stb, wr_at;
    logic [31:0] got [0:1];

    initial
    begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end

    ////////////////////////////////////////
    // released ad lines show a pattern that flips every cycle, released byte enables read high
    assign ad_in = (ad_out & ad_oe) | (~ad_oe & (i_ad_oe ? i_ad :
        (m_oe ? {m_dat, {24{flt}}} : {32{flt}})));
    assign cbe_n_in = cbe_oe ? cbe_n_out : (i_cbe_oe ? i_cbe : 4'hf);

    pbb_bridge u_pbb_bridge (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk_gen_strap(1'h1), .pci_clk_out(pci_clk_out),
        .pci_clk_oe(pci_clk_oe), .frame_n_in(frame_n), .irdy_n_in(irdy_n),
        .cbe_n_in(cbe_n_in), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
        .cbe_n_out(cbe_n_out), .cbe_oe(cbe_oe), .trdy_n_out(trdy_n_out), .trdy_oe(trdy_oe),
        .devsel_n_out(devsel_n_out), .devsel_oe(devsel_oe), .intb_n_out(intb_n_out),
        .intb_oe(intb_oe));

    pbb_byte_mem u_pbb_byte_mem (.pclk(pclk), .ad(ad_in), .strobe_n(cbe_n_in),
        .sel_n(intb_oe ? intb_n_out : 1'h1), .lag(lag), .rdata(m_dat), .rdata_oe(m_oe));

    always @(posedge pclk)
    begin
        flt <= ~flt;
        cyc <= cyc + 1;
        if (devsel_oe || cbe_oe || trdy_oe || intb_oe || ad_oe !== 32'h0)
            claimed <= 1'h1;
        if (cbe_oe)
            stb <= stb + 1;
        if (cbe_oe && !cbe_n_out[0] && !cbe_n_out[2])
            rd_lo <= rd_lo + 1;
        if (cbe_oe && !cbe_n_out[1] && !cbe_n_out[2])
        begin
            wr_lo <= wr_lo + 1;
            wr_at <= stb;
            wr_seen <= ad_in;
        end
    end

    ////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task finish_test;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    function automatic logic [31:0] cfg(input logic [2:0] ws, input logic en, input logic [4:0] dv);
        return {6'h16, 15'h0, ws, en, 2'h0, dv};
    endfunction

    // initiator side: address phase held three cycles so the input filter takes it
    task pci(input logic w, input logic [23:0] a, input logic [31:0] d, input int nb,
        input logic [5:0] base);
        stb = 0;
        rd_lo = 0;
        wr_lo = 0;
        claimed = 1'h0;
        @(posedge pclk);
        frame_n <= 1'h0;
        i_ad <= {base, a, 2'h0};
        i_ad_oe <= 1'h1;
        i_cbe <= w ? PBB_CMD_MEM_WR : PBB_CMD_MEM_RD;
        i_cbe_oe <= 1'h1;
        repeat (3) @(posedge pclk);
        frame_n <= (nb < 2);
        irdy_n <= 1'h0;
        i_ad <= d;
        i_ad_oe <= w;
        i_cbe_oe <= 1'h0;
        if (nb == 0)
            repeat (6) @(posedge pclk);
        for (int k = 0; k < nb; k++)
        begin
            do
                @(posedge pclk);
            while (trdy_n_out !== 1'h0);
            got[k] = ad_in;
            chk("global select", {31'h0, intb_n_out}, 32'h0);
            chk("device select", {31'h0, devsel_n_out}, 32'h0);
            frame_n <= 1'h1;
        end
        irdy_n <= 1'h1;
        i_ad_oe <= 1'h0;
        repeat (12) @(posedge pclk);
        chk("released", ad_oe | {28'h0, devsel_oe, trdy_oe, cbe_oe, intb_oe}, 32'h0);
    endtask

    ////////////////////////////////////////
    task t_clk(input int per);
        int t0;
        chk("clock drive", {31'h0, pci_clk_oe}, 32'h1);
        @(posedge pci_clk_out);
        @(negedge pclk);
        t0 = cyc;
        @(negedge pci_clk_out);
        @(negedge pclk);
        chk("clock high", 32'(cyc - t0), 32'(per / 2));
        @(posedge pci_clk_out);
        @(negedge pclk);
        chk("clock period", 32'(cyc - t0), 32'(per));
    endtask

    task t_regs;
        logic [31:0] r;
        logic e;
        apb(1'h0, PBB_CTRL_ADDR, 32'h0, r, e);
        chk("ctrl reset", r, 32'h0000_001f);
        chk("ctrl err", {31'h0, e}, 32'h0);
        apb(1'h1, PBB_CTRL_ADDR + 32'h4, 32'hffff_ffff, r, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        apb(1'h0, PBB_CTRL_ADDR + 32'h4, 32'h0, r, e);
        chk("unmapped data", r, 32'h0);
        apb(1'h1, PBB_CTRL_ADDR, cfg(3'h5, 1'h0, 5'h3), r, e);
        apb(1'h1, PBB_CTRL_ADDR, cfg(3'h2, 1'h0, 5'h0), r, e);
        apb(1'h0, PBB_CTRL_ADDR, 32'h0, r, e);
        chk("div zero kept", r, cfg(3'h2, 1'h0, 5'h3));
    endtask

    // clock enable low: divider and bus answer must stand still
    task t_hold;
        logic v;
        @(posedge pclk);
        pce <= 1'h0;
        @(negedge pclk);
        v = pci_clk_out;
        repeat (6) @(negedge pclk);
        chk("frozen clock", {31'h0, pci_clk_out}, {31'h0, v});
        chk("frozen ready", {31'h0, pready}, 32'h0);
        @(posedge pclk);
        pce <= 1'h1;
    endtask

    task t_off;
        logic [31:0] r;
        logic e;
        pci(1'h1, 24'h12, 32'ha500_0000, 0, 6'h16);
        chk("claim disabled", {31'h0, claimed}, 32'h0);
        apb(1'h1, PBB_CTRL_ADDR, cfg(3'h7, 1'h1, 5'h3), r, e);
        pci(1'h0, 24'h12, 32'h0, 0, 6'h17);
        chk("claim other base", {31'h0, claimed}, 32'h0);
    endtask

    task t_read;
        lag = 3'h1;
        pci(1'h0, 24'h11_0012, 32'h0, 1, 6'h16);
        chk("read word", got[0], {8'h12 ^ 8'h5a, 24'h11_0012});
        chk("read strobe", rd_lo, 8);
        chk("strobe phase", stb, 8);
    endtask

    task t_write;
        logic [31:0] r;
        logic e;
        for (int ws = 0; ws < 8; ws++)
        begin
            apb(1'h1, PBB_CTRL_ADDR, cfg(3'(ws), 1'h1, 5'h3), r, e);
            pci(1'h1, 24'(ws) + 24'h40, {8'(ws) + 8'hc0, 24'hff_ffff}, 1, 6'h16);
            chk("write bus", wr_seen, {8'(ws) + 8'hc0, 24'(ws) + 24'h40});
            chk("write mem", {24'h0, u_pbb_byte_mem.mem[ws + 8'h40]}, ws + 32'hc0);
            chk("write strobe", wr_lo, 1);
            chk("write delay", wr_at, ws);
            chk("write phase", stb, ws + 1);
        end
    endtask

    // frame is raised after the first byte, so the filter ends it after the second
    task t_burst;
        lag = 3'h0;
        pci(1'h0, 24'h00_0123, 32'h0, 2, 6'h16);
        chk("burst first", got[0], {8'h23 ^ 8'h5a, 24'h00_0123});
        chk("burst second", got[1], {8'h24 ^ 8'h5a, 24'h00_0124});
        chk("burst strobes", rd_lo, 16);
    endtask

    ////////////////////////////////////////
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {frame_n, irdy_n, i_ad, i_ad_oe, i_cbe, i_cbe_oe} = {2'h3, 32'h0, 1'h0, 4'hf, 1'h0};
        {flt, lag, claimed, wr_seen} = '0;
        pce = 1'h1;
        {err_count, compares, cyc, rd_lo, wr_lo, stb, wr_at} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(negedge pclk);
        t_clk(32);
        t_regs;
        t_hold;
        t_clk(4);
        t_off;
        t_read;
        t_write;
        t_burst;
        finish_test;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        finish_test;
    end
endmodule // pbb_bridge_tb
